// ### bench/test_tpw_pwm.sv
// Testbench: register-level scenarios for the PWM timer
`timescale 1ns/1ps
module test_tpw_pwm;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq_accept;
    logic pin_level, trig_pin, pwm_output_pin, irq_request;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] haddr, hwdata, hrdata, rd, high_len, low_len;
    int fails, checked, waited;
    int div_tab[4] = '{2, 16, 64, 512};

    tpw_pwm u_dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .trigger_input_pin(trig_pin),
        .irq_accept(irq_accept), .pwm_output_pin(pwm_output_pin),
        .irq_request(irq_request)
    );
    tpw_far_end u_far (
        .hclk(hclk), .pin_level(pin_level), .pwm_output_pin(pwm_output_pin),
        .trigger_input_pin(trig_pin), .high_len(high_len), .low_len(low_len)
    );
    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end
    ////////////////////////////////////////////////////////////////////
    task automatic results;
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : results
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic edges(input int n);
        repeat (n) @(posedge hclk);
    endtask : edges
    task automatic ready;
        edges(1);
        for (int n = 0; n < 50 && hreadyout !== 1'b1; n++) edges(1);
        if (hreadyout !== 1'b1) begin
            fails++;
            results();
        end
    endtask : ready
    task automatic ahb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        {hsel, htrans, hwrite, haddr} <= {3'b110, w, 24'h0, a};
        ready();
        {hsel, htrans, hwdata} <= {3'b000, d};
        ready();
        rd = hrdata;
    endtask : ahb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        ahb(1'b1, a, d);
    endtask : wr
    // Extra edge lets the far end log the segment that just ended
    task automatic wait_pwm(input logic lvl);
        for (waited = 0; waited < 4000 && pwm_output_pin !== lvl; waited++)
            edges(1);
        if (waited == 4000) begin
            fails++;
            results();
        end
        edges(1);
    endtask : wait_pwm
    ////////////////////////////////////////////////////////////////////
    initial begin
        {hresetn, hsel, hwrite, irq_accept, htrans} = 6'h0;
        {haddr, hwdata, hsize, pin_level} = {64'h0, 3'b010, 1'b1};
        fails = 0;
        checked = 0;
        edges(12);
        hresetn <= 1'b1;
        edges(1);
        chk(irq_request, 32'h0);
        wr(tpw_pkg::OFF_CTRL, 32'h3);
        edges(3);
        chk(irq_request, 32'h1);
        chk(pwm_output_pin, 32'h0);
        ahb(1'b0, tpw_pkg::OFF_CTRL, 32'h0);
        chk(rd, 32'h3);
        ahb(1'b0, 8'h20, 32'h0);
        chk(rd, 32'h0);
        wr(tpw_pkg::OFF_IRQ, 32'h1);
        for (int k = 0; k < 2; k++) begin
            wr(tpw_pkg::OFF_CTRL, k ? 32'h7 : 32'h3);
            wr(tpw_pkg::OFF_RELOAD, k ? 32'hFF : 32'h0);
            wr(tpw_pkg::OFF_RUN, 32'h1);
            edges(600);
            chk(high_len, 32'h0);
            chk(irq_request, 32'h0);
            wr(tpw_pkg::OFF_RUN, 32'h0);
        end
        // Odd source codes also use trigger select 01
        for (int s = 0; s < 4; s++) begin
            wr(tpw_pkg::OFF_CTRL, 32'(s * 64 + (s % 2) * 8 + 3));
            wr(tpw_pkg::OFF_RELOAD, 32'(s + 1));
            wr(tpw_pkg::OFF_RUN, 32'h1);
            wait_pwm(1'b1);
            wait_pwm(1'b0);
            chk(high_len, 32'((s + 1) * div_tab[s]));
            chk(irq_request, 32'h1);
            wr(tpw_pkg::OFF_IRQ, 32'h1);
            wr(tpw_pkg::OFF_RUN, 32'h0);
            edges(3);
            chk(irq_request, 32'h0);
        end
        wr(tpw_pkg::OFF_RELOAD, 32'h4);
        wr(tpw_pkg::OFF_RUN, 32'h1);
        wait_pwm(1'b1);
        wr(tpw_pkg::OFF_RUN, 32'h0);
        edges(3);
        chk(pwm_output_pin, 32'h0);
        chk(irq_request, 32'h1);
        irq_accept <= 1'b1;
        edges(1);
        irq_accept <= 1'b0;
        edges(1);
        chk(irq_request, 32'h0);
        wr(tpw_pkg::OFF_RELOAD, 32'h2);
        for (int e = 0; e < 2; e++) begin
            wr(tpw_pkg::OFF_CTRL, 32'h13 + 32'(e * 8));
            pin_level <= (e == 0);
            edges(4);
            pin_level <= (e != 0);
            edges(20);
            chk(pwm_output_pin, 32'h0);
            pin_level <= (e == 0);
            wr(tpw_pkg::OFF_RUN, 32'h1);
            edges(20);
            chk(pwm_output_pin, 32'h0);
            pin_level <= (e != 0);
            wait_pwm(1'b1);
            pin_level <= (e == 0);
            edges(1);
            pin_level <= (e != 0);
            wait_pwm(1'b0);
            chk(high_len, 32'h4);
            wr(tpw_pkg::OFF_RUN, 32'h0);
        end
        wr(tpw_pkg::OFF_CTRL, 32'h7);
        wr(tpw_pkg::OFF_RELOAD, 32'h201);
        wr(tpw_pkg::OFF_RUN, 32'h1);
        wait_pwm(1'b1);
        chk(waited >= 8 && waited <= 20, 32'h1);
        wait_pwm(1'b0);
        chk(high_len, 32'h8);
        wr(tpw_pkg::OFF_RELOAD, 32'h301);
        wait_pwm(1'b1);
        chk(low_len, 32'h3F4);
        wait_pwm(1'b0);
        chk(high_len, 32'hC);
        ahb(1'b0, tpw_pkg::OFF_STATUS, 32'h0);
        chk(rd[1:0], 32'h2);
        ahb(1'b0, tpw_pkg::OFF_RELOAD, 32'h0);
        chk(rd, 32'h301);
        wr(tpw_pkg::OFF_RUN, 32'h0);
        wr(tpw_pkg::OFF_IRQ, 32'h1);
        // One-shot to PWM raises nothing; event to PWM does
        wr(tpw_pkg::OFF_CTRL, 32'h2);
        wr(tpw_pkg::OFF_CTRL, 32'h3);
        edges(1);
        chk(irq_request, 32'h0);
        wr(tpw_pkg::OFF_CTRL, 32'h1);
        wr(tpw_pkg::OFF_CTRL, 32'h3);
        ahb(1'b0, tpw_pkg::OFF_IRQ, 32'h0);
        chk(rd, 32'h1);
        results();
    end
endmodule : test_tpw_pwm

// ### bench/tpw_far_end.sv
// Far end: trigger source and a load that times the PWM output
`timescale 1ns/1ps
module tpw_far_end (
    input wire logic hclk,
    input wire logic pin_level,
    input wire logic pwm_output_pin,
    output logic trigger_input_pin,
    output logic [31:0] high_len,
    output logic [31:0] low_len
);
    logic prev_q;
    logic [31:0] run_q;
    initial begin
        trigger_input_pin = 1'b1;
        prev_q = 1'b0;
        run_q = 32'h0;
        high_len = 32'h0;
        low_len = 32'h0;
    end
    // Pin is driven as an input of the timer, changing after an edge
    always @(posedge hclk) begin
        trigger_input_pin <= pin_level;
        prev_q <= pwm_output_pin;
        run_q <= run_q + 32'h1;
        if (pwm_output_pin !== prev_q) begin
            run_q <= 32'h1;
            if (prev_q === 1'b1) begin
                high_len <= run_q;
            end else begin
                low_len <= run_q;
            end
        end
    end
endmodule : tpw_far_end

// ### bench/tpw_pwm_sva.sv
// Checker: port properties of the PWM timer
`timescale 1ns/1ps
module tpw_pwm_sva (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    input wire logic irq_accept,
    input wire logic pwm_output_pin,
    input wire logic irq_request
);
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    logic wr_go;
    logic pwm;
    assign wr_go = hsel && htrans[1] && hwrite;
    assign pwm = pwm_output_pin;
    ////////////////////////////////////////////////////////////////////
    property p_okay;
        hreadyout && !hresp;
    endproperty
    a_okay: assert property (p_okay) else $error("bus answer not OKAY");
    property p_rst;
        disable iff (1'b0) !hresetn |-> !pwm && !irq_request;
    endproperty
    a_rst: assert property (p_rst) else $error("outputs in reset");
    property p_fall;
        $fell(pwm) |-> ##[0:1] irq_request;
    endproperty
    a_fall: assert property (p_fall) else $error("no request");
    // A request needs a falling edge or a mode write behind it
    property p_src;
        $rose(irq_request) |-> $past(pwm) || $past(pwm, 2)
            || $past(wr_go, 2) || $past(wr_go, 3);
    endproperty
    a_src: assert property (p_src) else $error("stray request");
    property p_acc;
        irq_accept && !pwm && !$past(pwm) && !$past(wr_go) |=> !irq_request;
    endproperty
    a_acc: assert property (p_acc) else $error("not cleared");
    property p_keep;
        $fell(irq_request) |-> $past(irq_accept) || $past(wr_go, 2);
    endproperty
    a_keep: assert property (p_keep) else $error("request lost");
    property p_high;
        $rose(pwm) |=> pwm;
    endproperty
    a_high: assert property (p_high) else $error("short high");
    property p_low;
        $fell(pwm) |=> !pwm;
    endproperty
    a_low: assert property (p_low) else $error("short low");
    property p_rd;
        $changed(hrdata) |-> $past(hsel && htrans[1] && !hwrite);
    endproperty
    a_rd: assert property (p_rd) else $error("read data moved");
endmodule : tpw_pwm_sva

bind tpw_pwm tpw_pwm_sva u_sva (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans),
    .hwrite(hwrite), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .irq_accept(irq_accept),
    .pwm_output_pin(pwm_output_pin), .irq_request(irq_request)
);

// ### hdl/tpw_clk_div.sv
// Count source divider: one-cycle enables at hclk/2, /16, /64 and /512
`timescale 1ns/1ps
module tpw_clk_div (
    input wire logic hclk,
    input wire logic hresetn,
    output logic [tpw_pkg::NUM_SRC-1:0] src_tick
);

    localparam int LOGS [tpw_pkg::NUM_SRC] = '{
        tpw_pkg::DIV2_LOG, tpw_pkg::DIV16_LOG,
        tpw_pkg::DIV64_LOG, tpw_pkg::DIV512_LOG};

    logic [tpw_pkg::DIV_CNT_W-1:0] div_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            div_q <= '0;
        end else begin
            div_q <= div_q + 1'b1;
        end
    end

    // All enables share one counter so the rates stay phase aligned
    genvar gi;
    generate
        for (gi = 0; gi < tpw_pkg::NUM_SRC; gi++) begin : g_src
            assign src_tick[gi] = &div_q[LOGS[gi]-1:0];
        end
    endgenerate

endmodule : tpw_clk_div

// ### hdl/tpw_pkg.sv
// Package: register map, field layout and constants of the PWM timer
package tpw_pkg;

    // Register byte offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_RUN = 8'h04;
    localparam logic [7:0] OFF_RELOAD = 8'h08;
    localparam logic [7:0] OFF_IRQ = 8'h0C;
    localparam logic [7:0] OFF_STATUS = 8'h10;

    // Reset values
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [15:0] RELOAD_RST = 16'h0000;

    // Field positions inside the control register
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_WIDTH8_BIT = 2;
    localparam int CTRL_TRIG_LSB = 3;
    localparam int CTRL_EDGE_BIT = 3;
    localparam int CTRL_SRC_LSB = 6;

    // Status register field positions
    localparam int STAT_OUT_BIT = 0;
    localparam int STAT_BUSY_BIT = 1;
    localparam int STAT_CNT_LSB = 16;

    // Operating modes
    localparam logic [1:0] MODE_TIMER = 2'b00;
    localparam logic [1:0] MODE_EVENT = 2'b01;
    localparam logic [1:0] MODE_ONESHOT = 2'b10;
    localparam logic [1:0] MODE_PWM = 2'b11;

    // Count source dividers: log2 of 2, 16, 64 and 512
    localparam int NUM_SRC = 4;
    localparam int DIV_CNT_W = 9;
    localparam int DIV2_LOG = 1;
    localparam int DIV16_LOG = 4;
    localparam int DIV64_LOG = 6;
    localparam int DIV512_LOG = 9;

    // Last unit index of a period for each modulator width (one less than units per period)
    localparam logic [15:0] PERIOD16_LAST = 16'hFFFE;
    localparam logic [15:0] PERIOD8_LAST = 16'h00FE;

    typedef struct packed {
        logic [1:0] cnt_src;
        logic rsvd;
        logic [1:0] trig_sel;
        logic width8;
        logic [1:0] mode;
    } tpw_ctrl_s;

    typedef enum logic [1:0] {
        ST_OFF,
        ST_ARMED,
        ST_DELAY,
        ST_OUTPUT
    } tpw_state_e;

endpackage : tpw_pkg

// ### hdl/tpw_pwm.sv
// PWM mode of a 16-bit timer with an AHB-Lite register slave
//
// Implementation choices: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
module tpw_pwm (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic trigger_input_pin,
    input wire logic irq_accept,
    output logic pwm_output_pin,
    output logic irq_request
);

    ////////////////////////////////////////////////////////////////////////
    // Declarations

    tpw_pkg::tpw_ctrl_s ctrl_q;
    logic run_q;
    logic [15:0] reload_q;
    logic irq_q;
    logic [15:0] act_q;
    logic [15:0] unit_q;
    logic [7:0] pre_q;
    logic out_q;
    logic trig_pin_q;
    logic run_prev_q;
    tpw_pkg::tpw_state_e state_q;
    // Trigger accepted while armed, still waiting for the tick that
    // lines the counter up with the count source
    logic start_q;
    logic start;

    logic wr_pend_q;
    logic [7:0] wr_addr_q;
    logic [31:0] rdata_q;

    logic [tpw_pkg::NUM_SRC-1:0] src_tick;
    logic tick;
    logic unit_adv;
    logic [7:0] pre_lim;
    logic [15:0] period_last;
    logic [7:0] rel_hi;
    logic rel_zero;
    logic trig_int;
    logic trig_ext;
    logic trigger;
    logic busy;
    logic pwm_mode;
    logic mode_enter_irq;
    logic out_d;
    logic fall;
    logic addr_ph;
    logic wr_ctrl;
    logic wr_run;
    logic wr_reload;
    logic wr_irq;
    tpw_pkg::tpw_ctrl_s ctrl_wdata;
    logic [31:0] rd_mux;

    ////////////////////////////////////////////////////////////////////////
    // AHB-Lite slave: zero wait states, always OKAY

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = rdata_q;
    assign addr_ph = hsel & hready & htrans[1];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
        end else if (hready) begin
            wr_pend_q <= addr_ph & hwrite;
            wr_addr_q <= haddr[7:0];
        end
    end

    // Unmapped or misaligned offsets match nothing: read zero, write dropped
    assign wr_ctrl = wr_pend_q && (wr_addr_q == tpw_pkg::OFF_CTRL);
    assign wr_run = wr_pend_q && (wr_addr_q == tpw_pkg::OFF_RUN);
    assign wr_reload = wr_pend_q && (wr_addr_q == tpw_pkg::OFF_RELOAD);
    assign wr_irq = wr_pend_q && (wr_addr_q == tpw_pkg::OFF_IRQ);
    assign ctrl_wdata = hwdata[7:0];

    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (haddr[7:0])
            tpw_pkg::OFF_CTRL: rd_mux[7:0] = ctrl_q;
            tpw_pkg::OFF_RUN: rd_mux[0] = run_q;
            tpw_pkg::OFF_RELOAD: rd_mux[15:0] = reload_q;
            tpw_pkg::OFF_IRQ: rd_mux[0] = irq_q;
            tpw_pkg::OFF_STATUS: begin
                rd_mux[tpw_pkg::STAT_OUT_BIT] = out_q;
                rd_mux[tpw_pkg::STAT_BUSY_BIT] = busy;
                rd_mux[tpw_pkg::STAT_CNT_LSB +: 16] = unit_q;
            end
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // Read data is captured at the address phase edge for the data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rdata_q <= 32'h0000_0000;
        end else if (addr_ph && !hwrite) begin
            rdata_q <= rd_mux;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Software registers

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_q <= tpw_pkg::CTRL_RST;
        end else if (wr_ctrl) begin
            ctrl_q <= ctrl_wdata;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            run_q <= 1'b0;
        end else if (wr_run) begin
            run_q <= hwdata[0];
        end
    end

    // Writes while running reach every register; a new reload takes effect at the next period end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            reload_q <= tpw_pkg::RELOAD_RST;
        end else if (wr_reload) begin
            reload_q <= hwdata[15:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Count source

    tpw_clk_div u_div (
        .hclk(hclk),
        .hresetn(hresetn),
        .src_tick(src_tick)
    );

    assign tick = src_tick[ctrl_q.cnt_src];

    ////////////////////////////////////////////////////////////////////////
    // Trigger detection

    assign pwm_mode = (ctrl_q.mode == tpw_pkg::MODE_PWM);
    assign busy = (state_q == tpw_pkg::ST_DELAY) ||
                  (state_q == tpw_pkg::ST_OUTPUT);
    assign rel_hi = reload_q[15:8];
    assign rel_zero = ctrl_q.width8 ? (rel_hi == 8'h00) :
                      (reload_q == 16'h0000);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            trig_pin_q <= 1'b0;
            run_prev_q <= 1'b0;
        end else begin
            trig_pin_q <= trigger_input_pin;
            run_prev_q <= run_q;
        end
    end

    assign trig_int = !ctrl_q.trig_sel[1] && run_q && !run_prev_q;
    // Edge bit 1 selects rising, 0 falling; edges need the run flag
    assign trig_ext = ctrl_q.trig_sel[1] && run_q &&
                      (ctrl_q.trig_sel[0] ? (trigger_input_pin && !trig_pin_q)
                                          : (!trigger_input_pin && trig_pin_q));
    assign trigger = trig_int | trig_ext;

    // The divider runs free, so starting off a tick would cut the first
    // unit short; the waveform starts up to one tick late instead
    // Dropping run cancels a trigger that still waits for its tick
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            start_q <= 1'b0;
        end else if (state_q != tpw_pkg::ST_ARMED || !run_q || tick) begin
            start_q <= 1'b0;
        end else if (trigger && !rel_zero) begin
            start_q <= 1'b1;
        end
    end

    // Zero width is checked again at the start itself
    assign start = (start_q || trigger) && !rel_zero && tick;

    ////////////////////////////////////////////////////////////////////////
    // Modulator

    // 8-bit mode: prescaler advances the width counter every m+1 ticks
    assign pre_lim = ctrl_q.width8 ? act_q[7:0] : 8'h00;
    assign unit_adv = tick && (pre_q == pre_lim);
    assign period_last = ctrl_q.width8 ? tpw_pkg::PERIOD8_LAST
                                       : tpw_pkg::PERIOD16_LAST;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_q <= tpw_pkg::ST_OFF;
        end else if (!pwm_mode) begin
            state_q <= tpw_pkg::ST_OFF;
        end else begin
            unique case (state_q)
                tpw_pkg::ST_OFF: state_q <= tpw_pkg::ST_ARMED;
                tpw_pkg::ST_ARMED: begin
                    // A zero width leaves the modulator stopped; the
                    // counter only starts on a count source tick
                    if (start) begin
                        state_q <= ctrl_q.width8 ? tpw_pkg::ST_DELAY
                                                 : tpw_pkg::ST_OUTPUT;
                    end
                end
                tpw_pkg::ST_DELAY: begin
                    if (!run_q) begin
                        state_q <= tpw_pkg::ST_ARMED;
                    end else if (unit_adv &&
                                 (unit_q + 16'h0001 == {8'h00, act_q[15:8]})) begin
                        state_q <= tpw_pkg::ST_OUTPUT;
                    end
                end
                tpw_pkg::ST_OUTPUT: begin
                    if (!run_q) begin
                        state_q <= tpw_pkg::ST_ARMED;
                    end
                end
            endcase
        end
    end

    // Triggers during DELAY or OUTPUT fall through untouched
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            act_q <= 16'h0000;
            unit_q <= 16'h0000;
            pre_q <= 8'h00;
        end else if (state_q == tpw_pkg::ST_ARMED) begin
            act_q <= reload_q;
            unit_q <= 16'h0000;
            pre_q <= 8'h00;
        end else if (busy && run_q && tick) begin
            pre_q <= (pre_q == pre_lim) ? 8'h00 : pre_q + 8'h01;
            if (unit_adv) begin
                if (state_q == tpw_pkg::ST_DELAY) begin
                    if (unit_q + 16'h0001 == {8'h00, act_q[15:8]}) begin
                        unit_q <= 16'h0000;
                    end else begin
                        unit_q <= unit_q + 16'h0001;
                    end
                end else if (unit_q == period_last) begin
                    unit_q <= 16'h0000;
                    act_q <= reload_q;
                end else begin
                    unit_q <= unit_q + 16'h0001;
                end
            end
        end
    end

    // High for the first n units of each period, low for the rest
    always_comb begin
        out_d = 1'b0;
        if (state_q == tpw_pkg::ST_OUTPUT && run_q) begin
            if (ctrl_q.width8) begin
                out_d = unit_q < {8'h00, act_q[15:8]};
            end else begin
                out_d = unit_q < act_q;
            end
        end
    end

    // Output is registered, so it trails the counter by one clock
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            out_q <= 1'b0;
        end else begin
            out_q <= out_d;
        end
    end

    assign pwm_output_pin = out_q;

    ////////////////////////////////////////////////////////////////////////
    // Interrupt request bit

    assign fall = out_q && !out_d;
    // One-shot mode is left out on purpose: only timer or event entry counts
    assign mode_enter_irq = wr_ctrl && !pwm_mode &&
                            (ctrl_wdata.mode == tpw_pkg::MODE_PWM) &&
                            ((ctrl_q.mode == tpw_pkg::MODE_TIMER) ||
                             (ctrl_q.mode == tpw_pkg::MODE_EVENT));

    // Setting wins over a clear in the same cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_q <= 1'b0;
        end else if (fall || mode_enter_irq) begin
            irq_q <= 1'b1;
        end else if (irq_accept || (wr_irq && hwdata[0])) begin
            irq_q <= 1'b0;
        end
    end

    assign irq_request = irq_q;

endmodule : tpw_pwm
